// >>> rtl/card_flags_regs.vh
// register map, field positions and reset values of the card status flag block
`ifndef CARD_FLAGS_REGS_VH
`define CARD_FLAGS_REGS_VH
`define REG_CTRL 12'h000
`define REG_EVT 12'h004
`define REG_R1 12'h008
`define REG_R2 12'h00C
`define REG_INT_STAT 12'h010
`define REG_INT_MASK 12'h014
`define REG_REGSEL 12'h018
// short response byte
`define B_IDLE 0
`define B_ERASE_RST 1
`define B_ILLEGAL 2
`define B_CRC 3
`define B_BLKLEN 6
// long response second byte
`define B_LOCKED 0
`define B_LOCK_FAIL 1
`define B_EXEC 2
`define B_CARD_ERR 3
`define B_ECC 4
`define B_WP_VIOL 5
`define B_OVERWRITE 7
// control bits
`define C_INIT_DONE 0
`define C_LOCK 1
`define C_READ_R1 2
`define C_READ_R2 3
`define C_READ_TOK 4
// command indices
`define CMD_ERASE_START 6'h23
`define CMD_ERASE_END 6'h24
`define CMD_ERASE 6'h26
`define CMD_STATUS 6'h0D
`define CMD_SEND_CSD 6'h09
`define CMD_SEND_CID 6'h0A
`define CMD_READ_OCR 6'h3A
`define RST_INT_MASK 8'h00
`endif

// >>> rtl/card_spi_status_flags.v
// status and error flag logic of a card in serial mode, with an apb register view
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "card_flags_regs.vh"
module card_spi_status_flags (
  input wire i_clock,
  input wire i_srst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  input wire i_cmd_valid,
  input wire [5:0] i_cmd_index,
  input wire i_crc_fail,
  input wire i_cmd_not_legal,
  input wire i_blklen_too_big,
  input wire i_blklen_illegal,
  input wire i_prog_protected,
  input wire i_switch_fail,
  input wire i_ecc_fail,
  input wire i_card_fault,
  input wire i_exec_fault,
  input wire i_erase_skip,
  input wire i_lock_fail,
  input wire i_csd_overwrite,
  input wire i_init_done,
  input wire i_locked,
  input wire i_erase_pending,
  input wire i_read_short,
  input wire i_read_long,
  input wire i_read_token,
  output reg [7:0] o_resp_short,
  output reg [15:0] o_resp_long,
  output reg [7:0] o_read_error_token,
  output reg o_erase_cancel,
  output reg o_reg_read_ok,
  output reg o_irq
);
  ////////////////////////////////////////////////////////////////////////
  // position of each sticky flag in the flag vector
  localparam NFLAG = 12;
  localparam F_BLKLEN = 0;
  localparam F_CRC = 1;
  localparam F_ILLEGAL = 2;
  localparam F_SWITCH = 3;
  localparam F_ERST = 4;
  localparam F_WPVIOL = 5;
  localparam F_ESKIP = 6;
  localparam F_LOCKF = 7;
  localparam F_OVW = 8;
  localparam F_ECC = 9;
  localparam F_CARDERR = 10;
  localparam F_EXEC = 11;
  ////////////////////////////////////////////////////////////////////////
  reg [NFLAG-1:0] flag_r;
  reg [NFLAG-1:0] set_vec;
  reg [NFLAG-1:0] clr_vec;
  reg idle_r;
  reg [7:0] ctrl_r;
  reg [7:0] evt_r;
  reg [7:0] int_stat_r;
  reg [7:0] int_mask_r;
  reg [7:0] r1_byte;
  reg [7:0] r2_byte;
  reg [7:0] evt_now;
  reg [31:0] rdata_nxt;
  reg rdata_err;
  wire sw_init_done;
  wire sw_lock;
  wire rd_short;
  wire rd_long;
  wire rd_tok;
  wire erase_cmd;
  wire set_erst;
  wire reg_cmd;
  wire clr_short;
  wire clr_long;
  wire clr_tok;
  wire apb_ack;
  wire apb_access;
  wire apb_wr;
  genvar g;
  ////////////////////////////////////////////////////////////////////////
  // ready rises one cycle into the access phase, with read data beside it
  assign apb_ack = i_psel & i_penable & ~o_pready;
  // the transfer completes at the edge where ready is seen high
  assign apb_access = i_psel & i_penable & o_pready;
  assign apb_wr = apb_access & i_pwrite;
  ////////////////////////////////////////////////////////////////////////
  // software side can emulate conditions through the event register
  assign sw_init_done = ctrl_r[`C_INIT_DONE];
  assign sw_lock = ctrl_r[`C_LOCK];
  assign rd_short = i_read_short | evt_r[7] & ctrl_r[`C_READ_R1];
  assign rd_long = i_read_long | evt_r[7] & ctrl_r[`C_READ_R2];
  assign rd_tok = i_read_token | evt_r[7] & ctrl_r[`C_READ_TOK];
  assign erase_cmd = (i_cmd_index == `CMD_ERASE_START) | (i_cmd_index == `CMD_ERASE_END) |
                     (i_cmd_index == `CMD_ERASE) | (i_cmd_index == `CMD_STATUS);
  assign set_erst = i_cmd_valid & i_erase_pending & ~erase_cmd;
  assign reg_cmd = (i_cmd_index == `CMD_SEND_CSD) | (i_cmd_index == `CMD_SEND_CID) |
                   (i_cmd_index == `CMD_READ_OCR);
  // a long read covers both bytes and the token, a token read only the ecc, card error and execution flags
  assign clr_short = rd_short | rd_long;
  assign clr_long = rd_long;
  assign clr_tok = rd_long | rd_tok;
  ////////////////////////////////////////////////////////////////////////
  // set and clear condition of every sticky flag
  always @* begin
    set_vec = {NFLAG{1'b0}};
    set_vec[F_BLKLEN] = i_blklen_too_big | i_blklen_illegal | evt_r[0];
    set_vec[F_WPVIOL] = i_prog_protected;
    set_vec[F_CRC] = i_crc_fail | evt_r[1];
    set_vec[F_ILLEGAL] = i_cmd_not_legal | evt_r[2];
    set_vec[F_SWITCH] = i_switch_fail;
    set_vec[F_ECC] = i_ecc_fail | evt_r[3];
    set_vec[F_CARDERR] = i_card_fault | evt_r[4];
    set_vec[F_EXEC] = i_exec_fault | evt_r[5];
    set_vec[F_ESKIP] = i_erase_skip;
    set_vec[F_LOCKF] = i_lock_fail | evt_r[6];
    set_vec[F_ERST] = set_erst;
    set_vec[F_OVW] = i_csd_overwrite;
    clr_vec = {NFLAG{1'b0}};
    clr_vec[F_BLKLEN] = clr_short;
    clr_vec[F_CRC] = clr_short;
    clr_vec[F_ILLEGAL] = clr_short;
    clr_vec[F_SWITCH] = clr_short;
    clr_vec[F_ERST] = clr_short;
    clr_vec[F_WPVIOL] = clr_long;
    clr_vec[F_ESKIP] = clr_long;
    clr_vec[F_LOCKF] = clr_long;
    clr_vec[F_OVW] = clr_long;
    clr_vec[F_ECC] = clr_tok;
    clr_vec[F_CARDERR] = clr_tok;
    clr_vec[F_EXEC] = clr_tok;
  end
  ////////////////////////////////////////////////////////////////////////
  // response bytes; switch failure shares the illegal bit
  always @* begin
    r1_byte = 8'h00;
    r1_byte[`B_IDLE] = idle_r;
    r1_byte[`B_ERASE_RST] = flag_r[F_ERST];
    r1_byte[`B_ILLEGAL] = flag_r[F_ILLEGAL] | flag_r[F_SWITCH];
    r1_byte[`B_CRC] = flag_r[F_CRC];
    r1_byte[`B_BLKLEN] = flag_r[F_BLKLEN];
    r2_byte = 8'h00;
    r2_byte[`B_LOCKED] = i_locked | sw_lock;
    r2_byte[`B_LOCK_FAIL] = flag_r[F_LOCKF] | flag_r[F_ESKIP];
    r2_byte[`B_EXEC] = flag_r[F_EXEC];
    r2_byte[`B_CARD_ERR] = flag_r[F_CARDERR];
    r2_byte[`B_ECC] = flag_r[F_ECC];
    r2_byte[`B_WP_VIOL] = flag_r[F_WPVIOL];
    r2_byte[`B_OVERWRITE] = flag_r[F_OVW];
    evt_now = 8'h00;
    evt_now[0] = set_vec[F_BLKLEN];
    evt_now[1] = set_vec[F_CRC];
    evt_now[2] = set_vec[F_ILLEGAL] | set_vec[F_SWITCH];
    evt_now[3] = set_vec[F_WPVIOL];
    evt_now[4] = set_vec[F_ECC] | set_vec[F_CARDERR] | set_vec[F_EXEC];
    evt_now[5] = set_vec[F_LOCKF] | set_vec[F_ESKIP];
    evt_now[6] = set_vec[F_ERST];
    evt_now[7] = set_vec[F_OVW];
  end
  ////////////////////////////////////////////////////////////////////////
  // sticky flags, set wins over clear-on-read
  generate
    for (g = 0; g < NFLAG; g = g + 1) begin : g_flag
      always @(posedge i_clock) begin
        if (i_srst) begin
          flag_r[g] <= 1'b0;
        end else begin
          flag_r[g] <= set_vec[g] | flag_r[g] & ~clr_vec[g];
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // idle state, left once initialisation completes
  always @(posedge i_clock) begin
    if (i_srst) begin
      idle_r <= 1'b1;
    end else if (i_init_done | sw_init_done) begin
      idle_r <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // registered response images
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_resp_short <= 8'h01;
      o_resp_long <= 16'h0100;
      o_read_error_token <= 8'h00;
      o_erase_cancel <= 1'b0;
      o_reg_read_ok <= 1'b0;
    end else begin
      o_resp_short <= r1_byte;
      o_resp_long <= {r1_byte, r2_byte};
      o_read_error_token <= {3'b000, r2_byte[5:1]};
      o_erase_cancel <= set_erst;
      o_reg_read_ok <= i_cmd_valid & reg_cmd;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // read data and error answer of the addressed register
  always @* begin
    rdata_nxt = 32'h00000000;
    rdata_err = 1'b0;
    case (i_paddr)
      `REG_CTRL: begin
        rdata_nxt = {24'h000000, ctrl_r};
      end
      `REG_EVT: begin
        rdata_nxt = 32'h00000000;
      end
      `REG_R1: begin
        rdata_nxt = {24'h000000, r1_byte};
      end
      `REG_R2: begin
        rdata_nxt = {16'h0000, r1_byte, r2_byte};
      end
      `REG_INT_STAT: begin
        rdata_nxt = {24'h000000, int_stat_r};
      end
      `REG_INT_MASK: begin
        rdata_nxt = {24'h000000, int_mask_r};
      end
      `REG_REGSEL: begin
        rdata_nxt = {31'h00000000, o_reg_read_ok};
      end
      default: begin
        rdata_err = 1'b1;
      end
    endcase
    if (i_pwrite) begin
      rdata_nxt = 32'h00000000;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state per access
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
      ctrl_r <= 8'h00;
      evt_r <= 8'h00;
      int_stat_r <= 8'h00;
      int_mask_r <= `RST_INT_MASK;
      o_irq <= 1'b0;
    end else begin
      o_pready <= apb_ack;
      if (apb_ack) begin
        o_prdata <= rdata_nxt;
        o_pslverr <= rdata_err;
      end else begin
        o_prdata <= 32'h00000000;
        o_pslverr <= 1'b0;
      end
      evt_r <= 8'h00;
      int_stat_r <= int_stat_r | evt_now;
      if (apb_wr) begin
        case (i_paddr)
          `REG_CTRL: begin
            ctrl_r <= i_pwdata[7:0];
          end
          `REG_EVT: begin
            evt_r <= i_pwdata[7:0];
          end
          `REG_INT_STAT: begin
            // write one to clear, a new event in the same cycle wins
            int_stat_r <= evt_now | int_stat_r & ~i_pwdata[7:0];
          end
          `REG_INT_MASK: begin
            int_mask_r <= i_pwdata[7:0];
          end
          default: begin
            ctrl_r <= ctrl_r;
          end
        endcase
      end
      o_irq <= |(int_stat_r & int_mask_r);
    end
  end
endmodule

// >>> dv/card_flags_asserts.sv
// port assertions for the card status flag block
`timescale 1ns/10ps
module card_flags_asserts (
  input wire i_clock,
  input wire i_srst,
  input wire i_cmd_valid,
  input wire [5:0] i_cmd_index,
  input wire i_crc_fail,
  input wire i_cmd_not_legal,
  input wire i_locked,
  input wire i_erase_pending,
  input wire i_read_short,
  input wire i_read_long,
  input wire [7:0] o_resp_short,
  input wire [15:0] o_resp_long,
  input wire [7:0] o_read_error_token,
  input wire o_erase_cancel,
  input wire o_reg_read_ok
);
  wire no_rd = !i_read_short && !i_read_long;
  wire reg_cmd = i_cmd_index == 6'h09 || i_cmd_index == 6'h0A || i_cmd_index == 6'h3A;
  wire seq_cmd = i_cmd_index inside {6'h23, 6'h24, 6'h26, 6'h0D};
  wire cancel_cmd = i_erase_pending && !seq_cmd;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  long_head_a: assert property (o_resp_long[15:8] == o_resp_short)
    else $error("long head differs from short");
  token_bits_a: assert property (o_read_error_token == {3'h0, o_resp_long[5:1]})
    else $error("token differs from long bits");
  crc_set_a: assert property ((i_crc_fail && no_rd) ##1 no_rd |=> o_resp_short[3])
    else $error("checksum flag missing");
  illegal_set_a: assert property ((i_cmd_not_legal && no_rd) ##1 no_rd |=> o_resp_short[2])
    else $error("illegal flag missing");
  crc_clear_a: assert property (!i_crc_fail[*3] ##0 i_read_short ##1 !i_crc_fail[*2]
    |=> !o_resp_short[3]) else $error("checksum flag not cleared");
  locked_a: assert property ($stable(i_locked)[*3] |-> o_resp_long[0] == i_locked)
    else $error("locked bit wrong");
  idle_reset_a: assert property ($fell(i_srst) |-> o_resp_short == 8'h01)
    else $error("idle bit wrong after reset");
  read_ok_a: assert property (i_cmd_valid |=> o_reg_read_ok == $past(reg_cmd))
    else $error("register read flag wrong");
  cancel_a: assert property (i_cmd_valid |=> o_erase_cancel == $past(cancel_cmd))
    else $error("erase cancel wrong");
endmodule

// >>> dv/host_model.sv
// host side model issuing commands and response reads
`timescale 1ns/10ps
module host_model (
  input wire i_clock,
  input wire i_go,
  input wire [5:0] i_index,
  input wire [2:0] i_take,
  output reg o_cmd_valid = 1'b0,
  output reg [5:0] o_cmd_index = 6'h00,
  output reg [2:0] o_take = 3'h0
);
  // index toggles while no command is valid
  always @(posedge i_clock) begin
    o_cmd_valid <= i_go;
    o_cmd_index <= i_go ? i_index : ~o_cmd_index;
    o_take <= i_take;
  end
endmodule

// >>> dv/card_spi_status_flags_tb.sv
// self-checking bench for the card status flag block
`timescale 1ns/10ps
module card_spi_status_flags_tb;
  logic i_clock = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, go = 0;
  logic i_init_done = 0, i_locked = 0, i_erase_pending = 0, err = 0;
  logic [11:0] i_paddr = 0, ev = 0;
  logic [31:0] i_pwdata = 0, rd, lf = 32'h95C585AA;
  logic [15:0] e;
  logic [5:0] idx = 0;
  logic [2:0] take = 0;
  wire i_cmd_valid, i_crc_fail, i_cmd_not_legal, i_blklen_too_big, i_blklen_illegal;
  wire i_prog_protected, i_switch_fail, i_ecc_fail, i_card_fault, i_exec_fault, i_erase_skip;
  wire i_lock_fail, i_csd_overwrite, i_read_short, i_read_long, i_read_token;
  wire o_pready, o_pslverr, o_erase_cancel, o_reg_read_ok, o_irq;
  wire [5:0] i_cmd_index;
  wire [31:0] o_prdata;
  wire [7:0] o_resp_short, o_read_error_token;
  wire [15:0] o_resp_long;
  logic [15:0] tab [12] = '{16'h0800, 16'h0400, 16'h4000, 16'h4000, 16'h0020, 16'h0400,
    16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0002, 16'h0080};
  logic [5:0] cl [7] = '{6'h09, 6'h0A, 6'h3A, 6'h23, 6'h24, 6'h26, 6'h0D};
  int fails = 0, comparisons = 0;
  assign {i_crc_fail, i_cmd_not_legal, i_blklen_too_big, i_blklen_illegal, i_prog_protected,
    i_switch_fail, i_ecc_fail, i_card_fault, i_exec_fault, i_erase_skip, i_lock_fail,
    i_csd_overwrite} = ev;
  card_spi_status_flags i_dut (.i_clock, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_cmd_valid, .i_cmd_index, .i_crc_fail,
    .i_cmd_not_legal, .i_blklen_too_big, .i_blklen_illegal, .i_prog_protected, .i_switch_fail,
    .i_ecc_fail, .i_card_fault, .i_exec_fault, .i_erase_skip, .i_lock_fail, .i_csd_overwrite,
    .i_init_done, .i_locked, .i_erase_pending, .i_read_short, .i_read_long, .i_read_token,
    .o_resp_short, .o_resp_long, .o_read_error_token, .o_erase_cancel, .o_reg_read_ok, .o_irq);
  host_model i_host (.i_clock, .i_go(go), .i_index(idx), .i_take(take),
    .o_cmd_valid(i_cmd_valid), .o_cmd_index(i_cmd_index),
    .o_take({i_read_short, i_read_long, i_read_token}));
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end
  task step(int n);
    repeat (n) @(posedge i_clock);
  endtask
  task chk(string nm, logic [31:0] x, logic [31:0] s);
    comparisons++;
    if (s !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1;
    do begin @(posedge i_clock); n++; end while (o_pready !== 1'b1 && n < 50);
    rd = o_prdata;
    err = o_pslverr;
    if (o_pready !== 1'b1) fails++;
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_clock);
  endtask
  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #30000;
    fails++;
    results;
  end
  initial begin
    step(4);
    i_srst <= 0;
    step(2);
    chk("idle", 16'h0100, o_resp_long);
    apb(0, 12'h014, 0); chk("mask", 0, rd);
    i_init_done <= 1; step(1); i_init_done <= 0; i_locked <= 1; step(4);
    chk("locked", 16'h0001, o_resp_long);
    i_locked <= 0; step(4);
    for (int k = 0; k < 12; k++) begin
      e = tab[k]; ev <= 12'h800 >> k; step(1); ev <= 0; step(4);
      chk("long", e, o_resp_long);
      chk("token", {3'h0, e[5:1]}, o_read_error_token);
      take <= (k > 5 && k < 9) ? 3'h1 : 3'h2; step(1); take <= 0; step(4);
      chk("clear", 0, o_resp_long);
    end
    $display("event tests done");
    apb(1, 12'h010, 32'h000000FF); ev <= 12'h800; step(1); ev <= 0; step(4);
    apb(0, 12'h010, 0); chk("stat", 32'h00000002, rd & 32'h000000FF); chk("irq", 0, o_irq);
    apb(1, 12'h014, 32'h000000FF); step(2); chk("irq", 1, o_irq);
    apb(1, 12'h010, 32'h00000002); step(2); chk("irq", 0, o_irq);
    apb(1, 12'h014, 0); step(2); chk("irq", 0, o_irq);
    apb(0, 12'h01C, 0); chk("unmapped", 0, rd); chk("slverr", 1, err);
    $display("register tests done");
    i_erase_pending <= 1;
    for (int i = 0; i < 16; i++) begin
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      idx <= i < 7 ? cl[i] : lf[5:0]; go <= 1; step(1); go <= 0; step(2);
      chk("readok", idx inside {6'h09, 6'h0A, 6'h3A}, o_reg_read_ok);
      chk("cancel", !(idx inside {6'h23, 6'h24, 6'h26, 6'h0D}), o_erase_cancel);
    end
    $display("command tests done");
    results;
  end
endmodule
bind card_spi_status_flags card_flags_asserts i_chk (.i_clock, .i_srst, .i_cmd_valid,
  .i_cmd_index, .i_crc_fail, .i_cmd_not_legal, .i_locked, .i_erase_pending, .i_read_short,
  .i_read_long, .o_resp_short, .o_resp_long, .o_read_error_token, .o_erase_cancel, .o_reg_read_ok);
